// file: trig_ctrl.sv
// Trigger activation: arming, lamps, stepping, counting, gating.
// Assumes a Wishbone master on clk_in
// and asynchronous trigger pins.
//
// Contract
// - Inactive: both lamps off
// - Active and waiting: both lamps green
// - Trigger event: lamp A red half second; in single type the code disarms at once and lamp A stays dark
// - Reset event: lamp B red one second; lit by external reset only, not by sequence restart
// - Active: refuse configuration commands, log error
// - Reset or preset accepted, deactivates triggering
// - Manual trigger equals remote and external trigger
// - Manual trigger only when enabled and configured
// - No manual trigger in addressed type
// - Sequence restart only sequenced, enabled, configured
// - Count events, report with path index
// - Maximum frequency is reciprocal of interval
// - Interval is settle time to ninety percent
// - Satellite paths add about one microsecond
// - At most sixteen paths, count per type
// - Path triggerable only if all modules are
// - Refuse activation if satellite unit silent
// - Relays settle 15 ms, solid state microseconds
// - Single type deactivates after first switch
// - Sequence steps, wraps last to first
//
// The implementer's own choices: the Wishbone slave port and the placing of the registers.
`timescale 1ns/100ps
`include "trig_ctrl_cfg.svh"

module trig_ctrl
    import trig_ctrl_pkg::*;
#(
    parameter int LED_A_CYCLES  = `LED_A_MS * (`CLK_HZ / 1000),
    parameter int LED_B_CYCLES  = `LED_B_MS * (`CLK_HZ / 1000),
    parameter int EM_SETTLE_CYC = `EM_SETTLE_US * (`CLK_HZ / 1000000)
)
(
    // Clock and reset
    input  wire logic        clk_in,
    input  wire logic        reset_in,
    // Wishbone slave
    input  wire logic        wb_cyc_in,
    input  wire logic        wb_stb_in,
    input  wire logic        wb_we_in,
    input  wire logic [7:0]  wb_adr_in,
    input  wire logic [3:0]  wb_sel_in,
    input  wire logic [31:0] wb_dat_in,
    output logic      [31:0] wb_dat_out,
    output logic             wb_ack_out,
    // External pins
    input  wire logic        trig_a_in,
    input  wire logic        trig_b_in,
    input  wire logic [3:0]  addr_in,
    input  wire logic [7:0]  module_trig_in,
    input  wire logic        sat_resp_in,
    // Relay side
    output logic      [3:0]  path_out,
    output logic             path_stb_out,
    output logic             settle_busy_out,
    output logic             cfg_cmd_out,
    output logic             cmd_refused_out,
    output logic             trigger_active_flag_out,
    // Status lamps
    output logic             led_a_green_out,
    output logic             led_a_red_out,
    output logic             led_b_green_out,
    output logic             led_b_red_out
);

    // Settle and satellite times in cycles
    localparam int SSR_SETTLE_CYC = (`SSR_SETTLE_NS + `CLK_NS - 1) / `CLK_NS;
    localparam int SAT_DELAY_CYC  = (`SAT_DELAY_NS + `CLK_NS - 1) / `CLK_NS;

    // -----------------------------------------------------------------------
    // State
    // -----------------------------------------------------------------------
    typedef struct packed {
        act_state_t        act;        // Trigger function armed
        trig_type_t        ttype;      // Selected trigger type
        logic [4:0]        seq_len;    // Sequence length
        logic [3:0]        psel;       // Path mask write pointer
        logic [15:0][9:0]  pmask;      // Per path mask
        logic [3:0]        idx;        // Currently switched path
        logic              started;    // A path switched since arm or sequence restart
        logic              skip;       // Next event switches nothing
        logic [31:0]       count;      // Trigger events
        logic [15:0]       err;        // Refused command count
        logic              refused;    // Last activation attempt refused
        logic [26:0]       led_a;      // Lamp A red time left
        logic [26:0]       led_b;      // Lamp B red time left
        logic [20:0]       settle;     // Relay settle time left
        logic              stb;        // Path strobe
        logic              cfg_cmd;    // Accepted configuration command
        logic              cmd_ref;    // Refused command pulse
        logic [31:0]       min_int;    // Minimum trigger interval, ns
        logic [31:0]       max_freq;   // Maximum trigger frequency, Hz
        logic              ack;        // Bus acknowledge
        logic [31:0]       rdata;      // Bus read data
        logic [2:0]        sa;         // Trigger A sync and edge stage
        logic [2:0]        sb;         // Trigger B sync and edge stage
        logic [7:0]        saddr;      // Address sync, two stages
        logic [15:0]       smod;       // Module status sync, two stages
        logic [1:0]        ssat;       // Satellite response sync
    } state_t;

    state_t state_ff;
    state_t nxt_state;

    // -----------------------------------------------------------------------
    // Path qualification and interval per path
    // -----------------------------------------------------------------------
    logic [15:0] path_ok;      // Path usable for triggering
    logic [15:0] path_need;    // Path required by the current type
    logic [15:0] path_sat;     // Required path reaches a satellite unit
    logic [15:0][31:0] path_ns; // Settle time per path

    genvar gi;
    generate
        for (gi = 0; gi < `NUM_PATHS; gi = gi + 1)
        begin : g_path
            // All modules of the path triggerable
            assign path_ok[gi] = (state_ff.pmask[gi][7:0] & ~state_ff.smod[15:8])
                                 == 8'h00;
            // Required: 1, 2 or sequence length
            assign path_need[gi] = (state_ff.ttype == TT_SINGLE) ? (gi == 0) :
                                   (state_ff.ttype == TT_TOGGLE) ? (gi < 2) :
                                   (5'(gi) < state_ff.seq_len);
            assign path_sat[gi] = path_need[gi] & state_ff.pmask[gi][`PMASK_SAT_BIT];
            // Time to 90 % only, no dwell
            assign path_ns[gi] = (state_ff.pmask[gi][`PMASK_EM_BIT]
                                  ? 32'(`EM_SETTLE_US * 1000) : 32'(`SSR_SETTLE_NS))
                               + (path_sat[gi] ? 32'(`SAT_DELAY_NS) : 32'h0);
        end
    endgenerate

    logic        cfg_done;     // All required paths triggerable
    logic        sat_fail;     // A needed satellite is silent
    logic [31:0] worst_ns;     // Slowest required path
    logic        any_em;       // A required path is mechanical

    // Worst case over the required paths
    always_comb
    begin
        worst_ns = 32'h0;
        any_em   = 1'b0;
        for (int i = 0; i < `NUM_PATHS; i++)
        begin
            if (path_need[i] && (path_ns[i] > worst_ns))
            begin
                worst_ns = path_ns[i];
            end
            if (path_need[i] && state_ff.pmask[i][`PMASK_EM_BIT])
            begin
                any_em = 1'b1;
            end
        end
    end

    assign cfg_done = ((path_need & ~path_ok) == 16'h0);
    assign sat_fail = (path_sat != 16'h0) && !state_ff.ssat[1];

    // -----------------------------------------------------------------------
    // Next state
    // -----------------------------------------------------------------------
    logic        bus_wr;       // Write at the ack edge
    logic        rise_a;       // External trigger edge
    logic        rise_b;       // External reset edge
    logic        manual;       // Manual or remote trigger request
    logic        seq_rst;      // Sequence restart request
    logic        ev_trig;      // Trigger event that steps the path
    logic        ev_rst;       // Reset event: external reset or sequence restart
    logic [3:0]  next_idx;     // Path chosen by this event

    always_comb
    begin
        nxt_state = state_ff;
        // Two-stage synchronisers; the edge detector compares stage two with stage three
        nxt_state.sa    = {state_ff.sa[1:0], trig_a_in};
        nxt_state.sb    = {state_ff.sb[1:0], trig_b_in};
        nxt_state.saddr = {state_ff.saddr[3:0], addr_in};
        nxt_state.smod  = {state_ff.smod[7:0], module_trig_in};
        nxt_state.ssat  = {state_ff.ssat[0], sat_resp_in};
        rise_a = state_ff.sa[1] && !state_ff.sa[2];
        rise_b = state_ff.sb[1] && !state_ff.sb[2];

        // Bus: ack one cycle after the request
        bus_wr = wb_cyc_in && wb_stb_in && wb_we_in && state_ff.ack && wb_sel_in[0];
        nxt_state.ack = wb_cyc_in && wb_stb_in && !state_ff.ack;

        // Manual and remote requests behave as one trigger source
        manual = bus_wr && (wb_adr_in == `REG_CMD)
                 && (wb_dat_in[`CMD_MANUAL_BIT] || wb_dat_in[`CMD_REMOTE_BIT]);
        seq_rst = bus_wr && (wb_adr_in == `REG_CMD) && wb_dat_in[`CMD_SEQRST_BIT];

        ev_trig = (state_ff.act == ST_ON)
                  && (rise_a || (manual && cfg_done
                                 && (state_ff.ttype != TT_ADDRESSED)));
        ev_rst  = (state_ff.act == ST_ON) && (rise_b || seq_rst);

        // Pulses last one cycle
        nxt_state.stb     = 1'b0;
        nxt_state.cfg_cmd = 1'b0;
        nxt_state.cmd_ref = 1'b0;

        // Lamp and settle timers run down
        nxt_state.led_a  = (state_ff.led_a != 27'h0) ? state_ff.led_a - 27'h1 : 27'h0;
        nxt_state.led_b  = (state_ff.led_b != 27'h0) ? state_ff.led_b - 27'h1 : 27'h0;
        nxt_state.settle = (state_ff.settle != 21'h0) ? state_ff.settle - 21'h1 : 21'h0;

        // Interval and its reciprocal
        nxt_state.min_int  = worst_ns;
        nxt_state.max_freq = (worst_ns != 32'h0) ? 32'(`NS_PER_S) / worst_ns
                                                 : 32'h0;

        // Path choice per type
        case (state_ff.ttype)
            TT_SINGLE:    next_idx = 4'h0;
            TT_TOGGLE:    next_idx = state_ff.started ? {3'h0, ~state_ff.idx[0]} : 4'h0;
            TT_SEQUENCED: next_idx = (!state_ff.started
                                      || ({1'b0, state_ff.idx} == state_ff.seq_len - 5'h1))
                                     ? 4'h0 : state_ff.idx + 4'h1;
            TT_ADDRESSED: next_idx = state_ff.saddr[7:4];
            default:      next_idx = 4'h0;
        endcase

        // Trigger event handling
        if (ev_trig)
        begin
            nxt_state.count = state_ff.count + 32'h1;
            nxt_state.led_a = 27'(LED_A_CYCLES);
            if (state_ff.skip)
            begin
                // Reset came first: count only
                nxt_state.skip = 1'b0;
            end
            else
            begin
                nxt_state.idx     = next_idx;
                nxt_state.started = 1'b1;
                nxt_state.stb     = 1'b1;
                // Mechanical relays settle far slower
                nxt_state.settle  = any_em ? 21'(EM_SETTLE_CYC)
                                  : 21'(SSR_SETTLE_CYC)
                                  + ((path_sat != 16'h0) ? 21'(SAT_DELAY_CYC) : 21'h0);
                if (state_ff.ttype == TT_SINGLE)
                begin
                    nxt_state.act = ST_OFF;
                end
            end
        end

        // Reset event: lamp B on external reset only, restart if sequenced
        if (ev_rst)
        begin
            if (rise_b)
            begin
                nxt_state.led_b = 27'(LED_B_CYCLES);
            end
            if ((state_ff.ttype == TT_SEQUENCED) && cfg_done)
            begin
                nxt_state.started = 1'b0;
                nxt_state.skip    = (state_ff.count == 32'h0) && !ev_trig;
            end
        end

        // Register writes
        if (bus_wr)
        begin
            case (wb_adr_in)
                `REG_CTRL:
                begin
                    if (wb_dat_in[`CTRL_ACT_BIT] && (state_ff.act == ST_OFF))
                    begin
                        if (cfg_done && !sat_fail)
                        begin
                            nxt_state.act     = ST_ON;
                            nxt_state.count   = 32'h0;
                            nxt_state.started = 1'b0;
                            nxt_state.skip    = 1'b0;
                            nxt_state.refused = 1'b0;
                        end
                        else
                        begin
                            nxt_state.refused = 1'b1;
                        end
                    end
                    else if (!wb_dat_in[`CTRL_ACT_BIT])
                    begin
                        nxt_state.act = ST_OFF;
                    end
                    // Type and length only change while disarmed
                    if (state_ff.act == ST_OFF)
                    begin
                        nxt_state.ttype = trig_type_t'(wb_dat_in[2:1]);
                        if ((wb_dat_in[7:3] >= `SEQ_LEN_MIN) && (wb_dat_in[7:3] <= `SEQ_LEN_MAX))
                        begin
                            nxt_state.seq_len = wb_dat_in[7:3];
                        end
                    end
                end
                `REG_CMD:
                begin
                    if (wb_dat_in[`CMD_PRESET_BIT])
                    begin
                        nxt_state.act = ST_OFF;
                    end
                    else if (wb_dat_in[`CMD_CFG_BIT])
                    begin
                        if (state_ff.act == ST_ON)
                        begin
                            nxt_state.cmd_ref = 1'b1;
                            nxt_state.err     = state_ff.err + 16'h1;
                        end
                        else
                        begin
                            nxt_state.cfg_cmd = 1'b1;
                        end
                    end
                end
                `REG_PATH_SEL:
                begin
                    nxt_state.psel = wb_dat_in[3:0];
                end
                `REG_PATH_MASK:
                begin
                    // Path contents are frozen while armed
                    if (state_ff.act == ST_OFF)
                    begin
                        nxt_state.pmask[state_ff.psel] = wb_dat_in[9:0];
                    end
                    else
                    begin
                        nxt_state.cmd_ref = 1'b1;
                        nxt_state.err     = state_ff.err + 16'h1;
                    end
                end
                default:
                begin
                    nxt_state.psel = state_ff.psel;
                end
            endcase
        end

        // Read data prepared at the request edge
        case (wb_adr_in)
            `REG_CTRL:      nxt_state.rdata = {24'h0, state_ff.seq_len,
                                               state_ff.ttype, state_ff.act};
            `REG_STATUS:    nxt_state.rdata = {23'h0, (state_ff.settle != 21'h0),
                                               state_ff.idx, 1'b0, state_ff.refused,
                                               cfg_done, state_ff.act};
            `REG_COUNT:     nxt_state.rdata = state_ff.count;
            `REG_PATH_SEL:  nxt_state.rdata = {28'h0, state_ff.psel};
            `REG_PATH_MASK: nxt_state.rdata = {22'h0, state_ff.pmask[state_ff.psel]};
            `REG_MIN_INT:   nxt_state.rdata = state_ff.min_int;
            `REG_MAX_FREQ:  nxt_state.rdata = state_ff.max_freq;
            `REG_ERR_CNT:   nxt_state.rdata = {16'h0, state_ff.err};
            default:        nxt_state.rdata = 32'h0;
        endcase

        // Disarmed: no lamp time carries over
        if (nxt_state.act == ST_OFF)
        begin
            nxt_state.led_a = 27'h0;
            nxt_state.led_b = 27'h0;
        end
    end

    // -----------------------------------------------------------------------
    // State register
    // -----------------------------------------------------------------------
    always_ff @(posedge clk_in)
    begin
        if (reset_in)
        begin
            state_ff         <= '0;
            state_ff.seq_len <= `SEQ_LEN_RST;
        end
        else
        begin
            state_ff <= nxt_state;
        end
    end

    // -----------------------------------------------------------------------
    // Outputs
    // -----------------------------------------------------------------------
    assign wb_dat_out              = state_ff.rdata;
    assign wb_ack_out              = state_ff.ack;
    assign path_out                = state_ff.idx;
    assign path_stb_out            = state_ff.stb;
    assign settle_busy_out         = (state_ff.settle != 21'h0);
    assign cfg_cmd_out             = state_ff.cfg_cmd;
    assign cmd_refused_out         = state_ff.cmd_ref;
    assign trigger_active_flag_out = (state_ff.act == ST_ON);
    // Lamps: dark disarmed, green waiting, red timed
    assign led_a_green_out = (state_ff.act == ST_ON) && (state_ff.led_a == 27'h0);
    assign led_a_red_out   = (state_ff.act == ST_ON) && (state_ff.led_a != 27'h0);
    assign led_b_green_out = (state_ff.act == ST_ON) && (state_ff.led_b == 27'h0);
    assign led_b_red_out   = (state_ff.act == ST_ON) && (state_ff.led_b != 27'h0);

endmodule : trig_ctrl

// file: trig_ctrl_cfg.svh
// Offsets, fields, reset values and timing of the trigger block.
// Assumes a 100 MHz clock and a 32-bit classic Wishbone bus.
`ifndef TRIG_CTRL_CFG_SVH
`define TRIG_CTRL_CFG_SVH

// ---------------------------------------------------------------------------
// Register byte offsets
// ---------------------------------------------------------------------------
`define REG_CTRL        8'h00
`define REG_CMD         8'h04
`define REG_STATUS      8'h08
`define REG_COUNT       8'h0c
`define REG_PATH_SEL    8'h10
`define REG_PATH_MASK   8'h14
`define REG_MIN_INT     8'h18
`define REG_MAX_FREQ    8'h1c
`define REG_ERR_CNT     8'h20

// ---------------------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------------------
`define CTRL_ACT_BIT    0
`define CMD_MANUAL_BIT  0
`define CMD_SEQRST_BIT  1
`define CMD_REMOTE_BIT  2
`define CMD_PRESET_BIT  3
`define CMD_CFG_BIT     4
`define PMASK_SAT_BIT   8
`define PMASK_EM_BIT    9

// ---------------------------------------------------------------------------
// Reset values, limits and timing
// ---------------------------------------------------------------------------
`define SEQ_LEN_RST     5'h03
`define SEQ_LEN_MIN     5'h03
`define SEQ_LEN_MAX     5'h10
`define NUM_PATHS       16
`define CLK_HZ          100000000
`define CLK_NS          10
`define LED_A_MS        500
`define LED_B_MS        1000
`define EM_SETTLE_US    15000
`define SSR_SETTLE_NS   3000
`define SAT_DELAY_NS    1000
`define NS_PER_S        1000000000

`endif

// file: trig_ctrl_pkg.sv
// Types of the trigger block.
// Assumes the cfg header holds the numbers.
package trig_ctrl_pkg;

    // -----------------------------------------------------------------------
    // Trigger types and activity state
    // -----------------------------------------------------------------------
    typedef enum logic [1:0] {
        TT_SINGLE    = 2'b00,
        TT_TOGGLE    = 2'b01,
        TT_SEQUENCED = 2'b10,
        TT_ADDRESSED = 2'b11
    } trig_type_t;

    typedef enum logic {
        ST_OFF = 1'b0,
        ST_ON  = 1'b1
    } act_state_t;

endpackage : trig_ctrl_pkg

// file: trig_ctrl_props.sv
// Checker for trig_ctrl lamps, strobe, gating and ack.
// Assumes a bind onto trig_ctrl.
`timescale 1ns/100ps
module trig_ctrl_props
#(
    parameter int LED_A_CYCLES = 20,
    parameter int LED_B_CYCLES = 40
)
(
    // Clock, reset and bus
    input wire logic clk_in,
    input wire logic reset_in,
    input wire logic wb_cyc_in,
    input wire logic wb_stb_in,
    input wire logic wb_ack_out,
    // Relay side
    input wire logic path_stb_out,
    input wire logic cfg_cmd_out,
    input wire logic cmd_refused_out,
    input wire logic trigger_active_flag_out,
    // Lamps
    input wire logic led_a_green_out,
    input wire logic led_a_red_out,
    input wire logic led_b_green_out,
    input wire logic led_b_red_out
);
    // ----------------------------------------------------------------
    // Red lamp duration counters
    // ----------------------------------------------------------------
    logic [31:0] red_a_ff;      // Cycles lamp A has been red
    logic [31:0] red_b_ff;      // Cycles lamp B has been red

    // Counts red cycles; a fall reads the span
    always_ff @(posedge clk_in)
    begin
        red_a_ff <= (led_a_red_out && !reset_in) ? red_a_ff + 32'h1 : 32'h0;
        red_b_ff <= (led_b_red_out && !reset_in) ? red_b_ff + 32'h1 : 32'h0;
    end

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (reset_in);

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    // Flag and lamps move together; one cycle of slack
    a_idle_lamps_off: assert property ((!trigger_active_flag_out)[*2] |->
        !(led_a_green_out || led_a_red_out || led_b_green_out || led_b_red_out))
        else $error("lamp lit while idle");
    a_armed_one_colour: assert property (trigger_active_flag_out[*2] |->
        (led_a_green_out ^ led_a_red_out) && (led_b_green_out ^ led_b_red_out))
        else $error("lamp not single colour while armed");
    a_red_a_length: assert property ($fell(led_a_red_out) && trigger_active_flag_out
        |-> red_a_ff inside {[LED_A_CYCLES-1:LED_A_CYCLES+1]}) else $error("lamp a red span");
    a_red_b_length: assert property ($fell(led_b_red_out) && trigger_active_flag_out
        |-> red_b_ff inside {[LED_B_CYCLES-1:LED_B_CYCLES+1]}) else $error("lamp b red span");
    a_switch_lights_red: assert property (path_stb_out && trigger_active_flag_out
        |-> led_a_red_out ##1 !path_stb_out) else $error("switch without red lamp");
    a_refuse_when_armed: assert property (cmd_refused_out |-> $past(trigger_active_flag_out))
        else $error("refusal while idle");
    a_accept_when_idle: assert property (cfg_cmd_out |-> !$past(trigger_active_flag_out))
        else $error("config accepted while armed");
    a_no_switch_idle: assert property ((!trigger_active_flag_out)[*2] |-> !path_stb_out)
        else $error("switch while idle");
    a_bus_ack_once: assert property (wb_cyc_in && wb_stb_in && !wb_ack_out
        |=> wb_ack_out ##1 !wb_ack_out) else $error("ack timing");

    // Main scenarios reached
    c_switch: cover property (path_stb_out);
    c_refused: cover property (cmd_refused_out);
    c_reset_event: cover property ($rose(led_b_red_out));
endmodule : trig_ctrl_props

bind trig_ctrl trig_ctrl_props #(.LED_A_CYCLES(LED_A_CYCLES), .LED_B_CYCLES(LED_B_CYCLES))
    trig_ctrl_props_i (.*);

// file: trig_pin_src.sv
// Trigger source: raises a pin for four cycles.
// Assumes one-cycle bench pulses on clk_in.
`timescale 1ns/100ps
module trig_pin_src
(
    // Clock and requests
    input  wire logic clk_in,
    input  wire logic fire_a_in,
    input  wire logic fire_b_in,
    // Pins toward the device
    output logic      trig_a_out,
    output logic      trig_b_out
);
    logic [2:0] hold_a_ff = 3'h0;   // Cycles left high on pin a
    logic [2:0] hold_b_ff = 3'h0;   // Cycles left high on pin b

    // Four cycles outlast the two-flop synchroniser
    always_ff @(posedge clk_in)
    begin
        hold_a_ff <= fire_a_in ? 3'h4 : ((hold_a_ff != 3'h0) ? hold_a_ff - 3'h1 : 3'h0);
        hold_b_ff <= fire_b_in ? 3'h4 : ((hold_b_ff != 3'h0) ? hold_b_ff - 3'h1 : 3'h0);
    end
    assign trig_a_out = (hold_a_ff != 3'h0);
    assign trig_b_out = (hold_b_ff != 3'h0);
endmodule : trig_pin_src

// file: trig_ctrl_tb_top.sv
// Bench for trig_ctrl: Wishbone tasks and pin events.
// Assumes trig_pin_src and short lamp times.
`timescale 1ns/100ps
`include "trig_ctrl_cfg.svh"
module trig_ctrl_tb_top import trig_ctrl_pkg::*;;
    logic clk_in = 1'b0, reset_in = 1'b1, wb_cyc_in = 1'b0, wb_stb_in = 1'b0, wb_we_in = 1'b0;
    logic [7:0] wb_adr_in = 8'h0, module_trig_in = 8'hff;
    logic [31:0] wb_dat_in = 32'h0, wb_dat_out, q;
    logic wb_ack_out, trig_a, trig_b, fire_a = 1'b0, fire_b = 1'b0, sat_resp_in = 1'b1;
    logic [3:0] path_out, leds;
    logic path_stb_out, trigger_active_flag_out, la_g, la_r, lb_g, lb_r, busy;
    int bad_count = 0, compares = 0;
    assign leds = {la_g, la_r, lb_g, lb_r};

    always #5 clk_in = ~clk_in;

    trig_ctrl #(.LED_A_CYCLES(20), .LED_B_CYCLES(40), .EM_SETTLE_CYC(50)) trig_ctrl_i (
        .clk_in, .reset_in, .wb_cyc_in, .wb_stb_in, .wb_we_in, .wb_adr_in, .wb_sel_in(4'hf),
        .wb_dat_in, .wb_dat_out, .wb_ack_out, .trig_a_in(trig_a), .trig_b_in(trig_b),
        .addr_in(4'h0), .module_trig_in, .sat_resp_in, .path_out, .path_stb_out,
        .settle_busy_out(busy), .cfg_cmd_out(), .cmd_refused_out(), .trigger_active_flag_out,
        .led_a_green_out(la_g), .led_a_red_out(la_r), .led_b_green_out(lb_g),
        .led_b_red_out(lb_r));
    trig_pin_src trig_pin_src_i (.clk_in, .fire_a_in(fire_a), .fire_b_in(fire_b),
        .trig_a_out(trig_a), .trig_b_out(trig_b));

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // Classic cycle held until ack
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n = 0;
        @(posedge clk_in);
        {wb_cyc_in, wb_stb_in, wb_we_in, wb_adr_in, wb_dat_in} <= {2'b11, w, a, d};
        while (wb_ack_out !== 1'b1 && n < 50)
        begin
            @(posedge clk_in);
            n++;
        end
        if (n == 50)
            bad_count++;
        q = wb_dat_out;
        {wb_cyc_in, wb_stb_in, wb_we_in} <= 3'b000;
    endtask : wb

    task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        wb(1'b0, a, 32'h0);
        chk(q & m, e);
    endtask : rdc

    // Kind 0 pin, 1 manual, 2 remote
    task automatic ev(input int kind, input logic [3:0] p);
        int n = 0;
        if (kind == 0)
            fire_a <= 1'b1;
        else
            wb(1'b1, `REG_CMD, (kind == 1) ? 32'h1 : 32'h4);
        @(posedge clk_in);
        fire_a <= 1'b0;
        while (path_stb_out !== 1'b1 && n < 30)
        begin
            @(posedge clk_in);
            n++;
        end
        chk({28'h0, path_out}, {28'h0, p});
        chk({31'h0, busy}, 32'h1);
        repeat (25) @(posedge clk_in);
    endtask : ev

    task automatic conclude();
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : conclude

    // Watchdog far beyond the test length
    initial
    begin
        repeat (20000) @(posedge clk_in);
        bad_count++;
        conclude();
    end

    initial
    begin
        repeat (16) @(posedge clk_in);
        reset_in <= 1'b0;
        chk({28'h0, leds}, 32'h0);
        for (int i = 0; i < 3; i++)
        begin
            wb(1'b1, `REG_PATH_SEL, i);
            wb(1'b1, `REG_PATH_MASK, 32'h1);
        end
        wb(1'b1, `REG_CTRL, 32'h1d);              // Sequenced, length 3, armed
        rdc(`REG_COUNT, 32'hffffffff, 32'h0);
        chk({28'h0, leds}, 32'ha);
        rdc(`REG_MIN_INT, 32'hffffffff, 32'hbb8);
        rdc(`REG_MAX_FREQ, 32'hffffffff, 32'h51615);
        wb(1'b1, `REG_CMD, 32'h10);
        rdc(`REG_ERR_CNT, 32'hffffffff, 32'h1);
        ev(0, 4'h0);
        ev(1, 4'h1);
        ev(2, 4'h2);
        ev(0, 4'h0);
        rdc(`REG_COUNT, 32'hffffffff, 32'h4);
        rdc(`REG_STATUS, 32'hf1, 32'h1);
        fire_b <= 1'b1;
        @(posedge clk_in);
        fire_b <= 1'b0;
        repeat (50) @(posedge clk_in);
        ev(1, 4'h0);
        wb(1'b1, `REG_CMD, 32'h8);
        rdc(`REG_CTRL, 32'h1, 32'h0);
        wb(1'b1, `REG_PATH_SEL, 32'h0);
        wb(1'b1, `REG_PATH_MASK, 32'h101);
        sat_resp_in <= 1'b0;
        repeat (4) @(posedge clk_in);
        wb(1'b1, `REG_CTRL, 32'h1);
        rdc(`REG_STATUS, 32'h5, 32'h4);
        sat_resp_in <= 1'b1;
        repeat (4) @(posedge clk_in);
        wb(1'b1, `REG_CTRL, 32'h1);
        rdc(`REG_MIN_INT, 32'hffffffff, 32'hfa0);
        ev(0, 4'h0);
        rdc(`REG_CTRL, 32'h1, 32'h0);
        rdc(`REG_COUNT, 32'hffffffff, 32'h1);
        module_trig_in <= 8'hfe;
        repeat (4) @(posedge clk_in);
        wb(1'b1, `REG_CTRL, 32'h1);
        rdc(`REG_STATUS, 32'h5, 32'h4);
        conclude();
    end
endmodule : trig_ctrl_tb_top
